// ===== hw/cce_map.svh
`ifndef CCE_MAP_SVH
`define CCE_MAP_SVH

// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define CCE_CALL_MASK   14'h3800
`define CCE_CALL_MATCH  14'h2000
`define CCE_ZFILE_MASK  14'h3F80
`define CCE_ZFILE_MATCH 14'h0180
`define CCE_ZACC_WORD   14'h0103
`define CCE_INV_MASK    14'h3F00
`define CCE_INV_MATCH   14'h0900

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCE_DEST_BIT    7
`define CCE_LATCH_HI    4
`define CCE_LATCH_LO    3

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCE_PC_RESET    13'h0000
`define CCE_ACC_RESET   8'h00

`endif

// ===== hw/cce_pkg.sv
`default_nettype none
package cce_pkg;

    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_CALL  = 3'b001,
        OP_ZFILE = 3'b010,
        OP_ZACC  = 3'b011,
        OP_INV   = 3'b100
    } cce_op_type;

    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_FLUSH = 1'b1
    } cce_state_type;

endpackage

`default_nettype wire

// ===== hw/cce_exec.sv
// Local design decisions: the valid/ready instruction port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "cce_map.svh"

module cce_exec
    import cce_pkg::*;
#(
    parameter int PC_W   = 13,
    parameter int DATA_W = 8,
    parameter int FA_W   = 7
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              instr_valid,
    input  wire logic [13:0]       instr_word,
    input  wire logic [DATA_W-1:0] file_rd_data,
    input  wire logic [4:0]        pc_upper_latch,
    output var  logic              instr_ready_reg,
    output var  logic [PC_W-1:0]   pc_reg,
    output var  logic [DATA_W-1:0] acc_reg,
    output var  logic              zero_flag_reg,
    output var  logic              file_we_reg,
    output var  logic [FA_W-1:0]   file_waddr_reg,
    output var  logic [DATA_W-1:0] file_wdata_reg,
    output var  logic              stack_push_reg,
    output var  logic [PC_W-1:0]   stack_top_entry_reg,
    output var  logic              decode_miss_reg
);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic cce_op_type op_decode(input logic [13:0] w);
        cce_op_type op;
        op = OP_NONE;
        if ((w & `CCE_CALL_MASK) == `CCE_CALL_MATCH) begin
            op = OP_CALL;
        end else if ((w & `CCE_ZFILE_MASK) == `CCE_ZFILE_MATCH) begin
            op = OP_ZFILE;
        end else if (w == `CCE_ZACC_WORD) begin
            op = OP_ZACC;
        end else if ((w & `CCE_INV_MASK) == `CCE_INV_MATCH) begin
            op = OP_INV;
        end
        return op;
    endfunction

    cce_op_type        cur_op;
    cce_state_type     state_reg;
    cce_state_type     state_next;
    logic              take;
    logic [DATA_W-1:0] inv_val;
    logic [PC_W-1:0]   pc_inc;

    assign take    = instr_valid && instr_ready_reg;
    assign cur_op  = op_decode(instr_word);
    assign inv_val = ~file_rd_data;
    assign pc_inc  = PC_W'(pc_reg + 1'b1);

    logic              ready_next;
    logic [PC_W-1:0]   pc_next;
    logic [DATA_W-1:0] acc_next;
    logic              zero_flag_next;
    logic              file_we_next;
    logic [FA_W-1:0]   file_waddr_next;
    logic [DATA_W-1:0] file_wdata_next;
    logic              stack_push_next;
    logic [PC_W-1:0]   stack_top_entry_next;
    logic              decode_miss_next;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        state_next           = state_reg;
        ready_next           = instr_ready_reg;
        pc_next              = pc_reg;
        acc_next             = acc_reg;
        zero_flag_next       = zero_flag_reg;
        file_we_next         = 1'b0;
        file_waddr_next      = file_waddr_reg;
        file_wdata_next      = file_wdata_reg;
        stack_push_next      = 1'b0;
        stack_top_entry_next = stack_top_entry_reg;
        decode_miss_next     = 1'b0;
        case (state_reg)
            ST_RUN: begin
                if (take) begin
                    pc_next = pc_inc;
                    case (cur_op)
                        OP_CALL: begin
                            stack_push_next      = 1'b1;
                            stack_top_entry_next = pc_inc;
                            pc_next = {pc_upper_latch[`CCE_LATCH_HI:`CCE_LATCH_LO],
                                       instr_word[10:0]};
                            state_next = ST_FLUSH;
                            ready_next = 1'b0;
                        end
                        OP_ZFILE: begin
                            file_we_next    = 1'b1;
                            file_waddr_next = instr_word[FA_W-1:0];
                            file_wdata_next = '0;
                            zero_flag_next  = 1'b1;
                        end
                        OP_ZACC: begin
                            acc_next       = '0;
                            zero_flag_next = 1'b1;
                        end
                        OP_INV: begin
                            zero_flag_next = (inv_val == '0);
                            if (instr_word[`CCE_DEST_BIT]) begin
                                file_we_next    = 1'b1;
                                file_waddr_next = instr_word[FA_W-1:0];
                                file_wdata_next = inv_val;
                            end else begin
                                acc_next = inv_val;
                            end
                        end
                        default: begin
                            decode_miss_next = 1'b1;
                        end
                    endcase
                end
            end
            ST_FLUSH: begin
                state_next = ST_RUN;
                ready_next = 1'b1;
            end
            default: begin
                state_next = ST_RUN;
                ready_next = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg           <= ST_RUN;
            instr_ready_reg     <= 1'b1;
            pc_reg              <= `CCE_PC_RESET;
            acc_reg             <= `CCE_ACC_RESET;
            zero_flag_reg       <= 1'b0;
            file_we_reg         <= 1'b0;
            file_waddr_reg      <= '0;
            file_wdata_reg      <= '0;
            stack_push_reg      <= 1'b0;
            stack_top_entry_reg <= `CCE_PC_RESET;
            decode_miss_reg     <= 1'b0;
        end else begin
            state_reg           <= state_next;
            instr_ready_reg     <= ready_next;
            pc_reg              <= pc_next;
            acc_reg             <= acc_next;
            zero_flag_reg       <= zero_flag_next;
            file_we_reg         <= file_we_next;
            file_waddr_reg      <= file_waddr_next;
            file_wdata_reg      <= file_wdata_next;
            stack_push_reg      <= stack_push_next;
            stack_top_entry_reg <= stack_top_entry_next;
            decode_miss_reg     <= decode_miss_next;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_CALL_PUSH: assert property (
        @(posedge clock) disable iff (rst)
        (take && cur_op == OP_CALL) |=>
            stack_push_reg && stack_top_entry_reg == PC_W'($past(pc_reg) + 1'b1))
        else $error("call did not push return address");

    AST_CALL_LOW: assert property (
        @(posedge clock) disable iff (rst)
        (take && cur_op == OP_CALL) |=> pc_reg[10:0] == $past(instr_word[10:0]))
        else $error("call literal not loaded");

    AST_CALL_HIGH: assert property (
        @(posedge clock) disable iff (rst)
        (take && cur_op == OP_CALL) |=>
            pc_reg[12:11] == $past(pc_upper_latch[4:3]) && $stable(zero_flag_reg)
            && $stable(acc_reg))
        else $error("call upper bits or flags wrong");

    AST_CALL_TWO: assert property (
        @(posedge clock) disable iff (rst)
        (take && cur_op == OP_CALL) |=> !instr_ready_reg ##1 instr_ready_reg)
        else $error("call not two cycles");

    AST_ZFILE: assert property (
        @(posedge clock) disable iff (rst)
        (take && cur_op == OP_ZFILE) |=>
            file_we_reg && file_wdata_reg == '0 && zero_flag_reg
            && file_waddr_reg == $past(instr_word[6:0]))
        else $error("clear file wrong");

    AST_INV_Z: assert property (
        @(posedge clock) disable iff (rst)
        (take && cur_op == OP_INV) |=> zero_flag_reg == ($past(file_rd_data) == 8'hFF))
        else $error("complement zero flag wrong");

    AST_INV_DEST: assert property (
        @(posedge clock) disable iff (rst)
        (take && cur_op == OP_INV) |=>
            (file_we_reg == $past(instr_word[7]))
            && (file_we_reg ? (file_wdata_reg == ~$past(file_rd_data) && $stable(acc_reg))
                            : (acc_reg == ~$past(file_rd_data))))
        else $error("complement destination wrong");

    AST_ZACC: assert property (
        @(posedge clock) disable iff (rst)
        (take && cur_op == OP_ZACC) |=> acc_reg == '0 && zero_flag_reg && !file_we_reg)
        else $error("clear accumulator wrong");

    AST_ONE_CYCLE: assert property (
        @(posedge clock) disable iff (rst)
        (take && (cur_op == OP_ZFILE || cur_op == OP_ZACC || cur_op == OP_INV)) |=>
            instr_ready_reg && !stack_push_reg && pc_reg == PC_W'($past(pc_reg) + 1'b1))
        else $error("single-cycle instruction took extra cycle");

endmodule

`default_nettype wire

// ===== testbench/cce_exec_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "cce_map.svh"
`define CHK(a, b) begin \
    comparisons++; \
    if ((a) !== (b)) begin \
        n_mismatch++; \
        $display("Error at %0t got %h expected %h", $time, (a), (b)); \
    end \
end

module testbench;
    import cce_pkg::*;
    logic        clock;
    logic        rst;
    logic        instr_valid;
    logic [13:0] instr_word;
    logic [7:0]  file_rd_data;
    logic [4:0]  pc_upper_latch;
    logic        ready;
    logic [12:0] pc;
    logic [7:0]  acc;
    logic        zf;
    logic        we;
    logic [6:0]  waddr;
    logic [7:0]  wdata;
    logic        push;
    logic [12:0] top;
    logic        miss;
    logic [12:0] pc_m;
    logic [7:0]  acc_m;
    logic        z_m;
    logic [31:0] seed;
    int          cyc;
    int          n_mismatch;
    int          comparisons;

    cce_exec u_dut (.clock(clock), .rst(rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .file_rd_data(file_rd_data),
        .pc_upper_latch(pc_upper_latch), .instr_ready_reg(ready), .pc_reg(pc),
        .acc_reg(acc), .zero_flag_reg(zf), .file_we_reg(we), .file_waddr_reg(waddr),
        .file_wdata_reg(wdata), .stack_push_reg(push), .stack_top_entry_reg(top),
        .decode_miss_reg(miss));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function cce_op_type kind_of(input logic [13:0] w);
        if ((w & `CCE_CALL_MASK) == `CCE_CALL_MATCH) return OP_CALL;
        if ((w & `CCE_ZFILE_MASK) == `CCE_ZFILE_MATCH) return OP_ZFILE;
        if (w == `CCE_ZACC_WORD) return OP_ZACC;
        if ((w & `CCE_INV_MASK) == `CCE_INV_MATCH) return OP_INV;
        return OP_NONE;
    endfunction

    task report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic issue(input logic [13:0] w, input logic [7:0] d, input logic [4:0] lat);
        cce_op_type k;
        logic [12:0] tgt;
        logic        we_e;
        logic [7:0]  wd_e;
        k = kind_of(w);
        tgt = {lat[4:3], w[10:0]};
        we_e = 1'b0;
        wd_e = 8'h00;
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_word <= w;
        file_rd_data <= d;
        pc_upper_latch <= lat;
        @(posedge clock);
        instr_valid <= (k == OP_CALL);
        instr_word <= `CCE_ZACC_WORD;
        #1;
        if (k == OP_CALL) begin
            `CHK(push, 1'b1)
            `CHK(top, pc_m + 13'h0001)
            `CHK(pc, tgt)
            `CHK(zf, z_m)
            `CHK(ready, 1'b0)
            @(posedge clock);
            #1;
            `CHK(ready, 1'b1)
            `CHK(pc, tgt)
            `CHK(push, 1'b0)
            @(posedge clock);
            instr_valid <= 1'b0;
            #1;
            pc_m = tgt + 13'h0001;
            acc_m = 8'h00;
            z_m = 1'b1;
        end else begin
            pc_m = pc_m + 13'h0001;
            if (k == OP_ZFILE) begin
                we_e = 1'b1;
                z_m = 1'b1;
            end else if (k == OP_ZACC) begin
                acc_m = 8'h00;
                z_m = 1'b1;
            end else if (k == OP_INV) begin
                z_m = (~d == 8'h00);
                we_e = w[`CCE_DEST_BIT];
                wd_e = ~d;
                if (!we_e) acc_m = ~d;
            end
            `CHK(we, we_e)
            if (we_e) `CHK(waddr, w[6:0])
            if (we_e) `CHK(wdata, wd_e)
            `CHK(miss, (k == OP_NONE))
            `CHK(push, 1'b0)
        end
        `CHK(pc, pc_m)
        `CHK(acc, acc_m)
        `CHK(zf, z_m)
    endtask

    // ----------------------------------------
    // clock, timeout, sequence
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        logic [31:0] a;
        logic [31:0] b;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = 14'h0000;
        file_rd_data = 8'h00;
        pc_upper_latch = 5'h00;
        seed = 32'ha34c_9342;
        pc_m = 13'h0000;
        acc_m = 8'h00;
        z_m = 1'b0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        #1;
        `CHK(ready, 1'b1)
        `CHK(pc, 13'h0000)
        issue(14'h2000, 8'h00, 5'h18);
        issue(14'h27FF, 8'h00, 5'h07);
        issue(14'h01FF, 8'h5A, 5'h00);
        issue(14'h0905, 8'h13, 5'h00);
        issue(14'h0983, 8'h13, 5'h00);
        issue(14'h0903, 8'hFF, 5'h00);
        issue(14'h0103, 8'h00, 5'h00);
        issue(14'h0064, 8'h00, 5'h00);
        issue(14'h0905, 8'h13, 5'h00);
        issue(14'h01FF, 8'h5A, 5'h00);
        // mid-run reset with non-zero accumulator and zero flag set
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        `CHK(ready, 1'b1)
        `CHK(pc, 13'h0000)
        `CHK(acc, 8'h00)
        `CHK(zf, 1'b0)
        `CHK(push, 1'b0)
        `CHK(we, 1'b0)
        pc_m = 13'h0000;
        acc_m = 8'h00;
        z_m = 1'b0;
        issue(14'h2123, 8'h00, 5'h08);
        for (int i = 0; i < 300; i++) begin
            a = xs();
            b = xs();
            case (a[2:0])
                3'h0: issue({3'h4, b[10:0]}, a[15:8], a[20:16]);
                3'h1: issue({7'h03, b[6:0]}, a[15:8], a[20:16]);
                3'h2: issue(`CCE_ZACC_WORD, a[15:8], a[20:16]);
                3'h3, 3'h4: issue({6'h09, b[7:0]}, a[15:8], a[20:16]);
                default: issue(b[13:0], a[15:8], a[20:16]);
            endcase
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
